// ==== rbw_ctl_reg.sv ====
// One retained control register: cleared by reset and cold start only
`default_nettype none
module rbw_ctl_reg
  import rbw_pkg::*;
#(
  parameter int unsigned W = 4
) (
  input  wire logic clk,
  input  wire logic rst,
  rbw_reg_if.store  port
);
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  // Back-up entry never touches this value; only reset and cold start clear it
  assign q_d = port.clr ? W'(REG_RESET_VAL) : (port.wr ? port.wdata : q_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      q_q <= W'(REG_RESET_VAL);
    end else begin
      q_q <= q_d;
    end
  end

  assign port.q = q_q;
endmodule : rbw_ctl_reg
`default_nettype wire

// ==== rbw_ctrl.sv ====
// RAM back-up entry, external wakeup and warm/cold start control
`default_nettype none
module rbw_ctrl
  import rbw_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 instr_valid,
  input  wire rbw_pkg::rbw_op_t     instr_op,
  input  wire logic [3:0]           instr_reg_sel,
  input  wire logic [3:0]           acc_in,
  output logic      [3:0]           acc_out,
  output logic                      skip_next,
  input  wire logic                 reset_pin_n,
  input  wire logic                 soft_system_reset_cmd,
  input  wire logic                 watchdog_reset,
  input  wire logic                 power_on_reset,
  input  wire logic                 supply_drop_reset,
  input  wire logic                 supply_drop_level,
  input  wire logic [3:0]           port0_in,
  input  wire logic [3:0]           port1_in,
  input  wire logic [1:0]           port2_in,
  input  wire logic                 port_k_in,
  input  wire logic                 ext_irq_pin_zero,
  input  wire logic                 ext_irq_pin_one,
  output logic                      osc_enable,
  output logic                      cpu_hold,
  output logic                      cpu_restart,
  output logic [13:0]               restart_addr,
  output logic                      backup_init,
  output logic [2:0]                stack_init_val,
  output logic                      ports_hold,
  output logic                      carrier_counter_pin_low,
  output logic                      supply_drop_enable,
  output logic                      supply_drop_flag,
  output logic                      ext_irq0_flag_set,
  output logic                      ext_irq1_flag_set,
  output logic                      powerdown_flag,
  output logic [3:0]                pullup_port0,
  output logic [3:0]                pullup_port1,
  output logic [3:0]                pullup_port2,
  output logic [3:0]                irq0_pin_control,
  output logic [3:0]                irq1_pin_control
);
  rbw_state_t              state_q;
  rbw_state_t              state_d;
  logic                    armed_q;
  logic                    pdflag_q;
  logic                    pdflag_d;
  logic [STAB_CNT_W-1:0]   stab_cnt_q;
  logic [STAB_CNT_W-1:0]   stab_cnt_d;
  logic [3:0]              acc_out_q;
  logic                    skip_q;
  logic                    restart_q;
  logic                    init_q;
  logic                    irq0_set_q;
  logic                    irq1_set_q;
  logic [3:0]              reg_q [NUM_REGS];

  // Instruction decode
  wire in_run       = (state_q == ST_RUN);
  wire in_backup    = (state_q == ST_BACKUP);
  wire in_stab      = (state_q == ST_STABILISE);
  wire op_arm       = instr_valid && in_run && (instr_op == OP_ARM);
  wire op_enter     = instr_valid && in_run && (instr_op == OP_ENTER);
  wire op_skip      = instr_valid && in_run && (instr_op == OP_SKIP_WARM);
  wire op_wr        = instr_valid && in_run && (instr_op == OP_WRITE_REG);
  wire op_rd        = instr_valid && in_run && (instr_op == OP_READ_REG);
  wire sel_ok       = (32'(instr_reg_sel) < NUM_REGS);
  wire enter_backup = op_enter && armed_q;

  // Supply-drop reset is ignored while the detector is switched off
  wire drop_reset_live = supply_drop_reset && !in_backup;
  wire pin_reset_hit   = !reset_pin_n;
  // Every cold source ends in the same restart; the flag tells software which
  // kind of start it was, not which source caused it
  wire cold_start      = pin_reset_hit || soft_system_reset_cmd || watchdog_reset ||
                         power_on_reset || drop_reset_live;

  // Retained registers, one instance per slot
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      rbw_reg_if #(.W(NIB_W)) rif ();
      assign rif.wr    = op_wr && (instr_reg_sel == REG_IDX_W'(gi)) && !cold_start;
      assign rif.wdata = acc_in;
      assign rif.clr   = cold_start;
      assign reg_q[gi] = rif.q;
      rbw_ctl_reg #(.W(NIB_W)) u_reg (
        .clk  (clk),
        .rst  (rst),
        .port (rif.store)
      );
    end
  endgenerate

  wire [3:0] key0_en  = reg_q[REG_KEY_WAKE0];
  wire [3:0] key1_en  = reg_q[REG_KEY_WAKE1];
  wire [3:0] key2_en  = reg_q[REG_KEY_WAKEK2];
  wire [3:0] wake_cnd = reg_q[REG_WAKE_COND];

  // Key-on wakeup: falling edge on any enabled bit
  wire [KEY_BITS-1:0] key_sample = {port_k_in, port2_in, port1_in, port0_in};
  wire [KEY_BITS-1:0] key_enable = {key2_en[K2_PORTK], key2_en[K2_P21], key2_en[K2_P20],
                                    key1_en, key0_en};
  wire [KEY_BITS-1:0] key_fall;

  rbw_fall_wake #(.W(KEY_BITS)) u_key_wake (
    .clk      (clk),
    .rst      (rst),
    .watch    (in_backup),
    .sample   (key_sample),
    .enable   (key_enable),
    .fall_hit (key_fall),
    .low_hit  ()
  );

  // Interrupt pins: inverting by the valid polarity turns both level and
  // edge choices into a low level or a falling edge
  // The input enable bit of a pin control register is storage only; the wake
  // condition register alone decides whether a pin may wake the device
  wire       pol0       = reg_q[REG_IRQ0_CTL][PIN_POL_BIT];
  wire       pol1       = reg_q[REG_IRQ1_CTL][PIN_POL_BIT];
  wire [1:0] pin_sample = {ext_irq_pin_one ^ pol1, ext_irq_pin_zero ^ pol0};
  wire [1:0] pin_enable = {wake_cnd[WC_IRQ1_EN], wake_cnd[WC_IRQ0_EN]};
  wire [1:0] pin_edge   = {wake_cnd[WC_IRQ1_EDGE], wake_cnd[WC_IRQ0_EDGE]};
  wire [1:0] pin_fall;
  wire [1:0] pin_low;

  rbw_fall_wake #(.W(2)) u_pin_wake (
    .clk      (clk),
    .rst      (rst),
    .watch    (in_backup),
    .sample   (pin_sample),
    .enable   (pin_enable),
    .fall_hit (pin_fall),
    .low_hit  (pin_low)
  );

  // Zero selects level return, one selects edge return
  wire [1:0] pin_edge_wake  = pin_fall & pin_edge;
  wire [1:0] pin_level_wake = pin_low & ~pin_edge;
  wire       wake_event     = (|key_fall) || (|pin_edge_wake) || (|pin_level_wake);
  // Wait rounded up to whole cycles so it never falls short of the oscillator time
  wire       stab_done      = (stab_cnt_q == STAB_CNT_W'(OSC_STAB_CYC - 1));
  wire       wake_done      = in_stab && stab_done;

  // Sequencer
  // The block's own logic keeps running in back-up: it stands for the always-on
  // wake detectors, while osc_enable stops the core clock outside it
  always_comb begin
    state_d    = state_q;
    stab_cnt_d = stab_cnt_q;
    case (state_q)
      ST_RUN: begin
        if (enter_backup) begin
          state_d = ST_BACKUP;
        end
      end
      ST_BACKUP: begin
        stab_cnt_d = '0;
        if (wake_event) begin
          state_d = ST_STABILISE;
        end
      end
      ST_STABILISE: begin
        stab_cnt_d = stab_cnt_q + STAB_CNT_W'(1);
        if (stab_done) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    if (cold_start) begin
      state_d    = ST_RUN;
      stab_cnt_d = '0;
    end
  end

  // Power-down flag: a cold start outranks entry in the same cycle
  always_comb begin
    pdflag_d = pdflag_q;
    if (cold_start) begin
      pdflag_d = 1'b0;
    end else if (enter_backup) begin
      pdflag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= ST_RUN;
      stab_cnt_q <= '0;
      pdflag_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      stab_cnt_q <= stab_cnt_d;
      pdflag_q   <= pdflag_d;
    end
  end

  // Arming lasts exactly one instruction; any other instruction disarms
  // Idle cycles between arm and enter leave the arming in place
  always_ff @(posedge clk) begin
    if (rst || cold_start) begin
      armed_q <= 1'b0;
    end else if (instr_valid) begin
      armed_q <= op_arm;
    end
  end

  // Restart pulse ends both cold start and stabilised wakeup
  always_ff @(posedge clk) begin
    if (rst) begin
      restart_q <= 1'b1;
      init_q    <= 1'b0;
    end else begin
      restart_q <= cold_start || wake_done;
      init_q    <= enter_backup && !cold_start;
    end
  end

  // Only edge returns raise the external interrupt request flags
  // A level return would hold while the pin stays active, so it raises none
  always_ff @(posedge clk) begin
    if (rst) begin
      irq0_set_q <= 1'b0;
      irq1_set_q <= 1'b0;
    end else begin
      irq0_set_q <= in_backup && pin_edge_wake[0];
      irq1_set_q <= in_backup && pin_edge_wake[1];
    end
  end

  // Accumulator reads and the warm-start skip test
  // Slots past the last register read as zero rather than as an unknown
  wire [3:0] rd_data = sel_ok ? reg_q[instr_reg_sel] : 4'h0;

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_out_q <= 4'h0;
      skip_q    <= 1'b0;
    end else begin
      if (op_rd) begin
        acc_out_q <= rd_data;
      end
      skip_q <= op_skip && pdflag_q;
    end
  end

  // Outputs
  // Pin holds follow the state directly, so they end as the oscillator restarts
  assign acc_out                 = acc_out_q;
  assign skip_next               = skip_q;
  assign osc_enable              = !in_backup;
  assign cpu_hold                = !in_run;
  assign cpu_restart             = restart_q;
  assign restart_addr            = RESTART_ADDR;
  assign backup_init             = init_q;
  assign stack_init_val          = SP_BACKUP_VAL;
  assign ports_hold              = in_backup;
  assign carrier_counter_pin_low = in_backup;
  assign supply_drop_enable      = !in_backup;
  assign supply_drop_flag        = supply_drop_level && !in_backup;
  assign ext_irq0_flag_set       = irq0_set_q;
  assign ext_irq1_flag_set       = irq1_set_q;
  assign powerdown_flag          = pdflag_q;
  assign pullup_port0            = reg_q[REG_PULLUP0];
  assign pullup_port1            = reg_q[REG_PULLUP1];
  assign pullup_port2            = reg_q[REG_PULLUP2];
  assign irq0_pin_control        = reg_q[REG_IRQ0_CTL];
  assign irq1_pin_control        = reg_q[REG_IRQ1_CTL];
endmodule : rbw_ctrl
`default_nettype wire

// ==== rbw_ctrl_monitor.sv ====
// Concurrent checks on the back-up and wakeup controller ports
`default_nettype none
module rbw_ctrl_monitor
  import rbw_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             instr_valid,
  input wire rbw_pkg::rbw_op_t instr_op,
  input wire logic             reset_pin_n,
  input wire logic             soft_system_reset_cmd,
  input wire logic             watchdog_reset,
  input wire logic             power_on_reset,
  input wire logic             supply_drop_reset,
  input wire logic             supply_drop_level,
  input wire logic             osc_enable,
  input wire logic             cpu_hold,
  input wire logic             cpu_restart,
  input wire logic             backup_init,
  input wire logic [2:0]       stack_init_val,
  input wire logic             ports_hold,
  input wire logic             carrier_counter_pin_low,
  input wire logic             supply_drop_enable,
  input wire logic             supply_drop_flag,
  input wire logic             powerdown_flag,
  input wire logic             skip_next
);
  timeunit 1ns;
  timeprecision 1ns;
  // A cold start restarts everything, so every check is dropped across one
  wire logic cold = !reset_pin_n || soft_system_reset_cmd || watchdog_reset ||
    power_on_reset || (supply_drop_reset && supply_drop_enable);
  wire logic run_ok = instr_valid && !cpu_hold;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || cold);
  AST_ENTRY : assert property (
    (run_ok && instr_op == OP_ARM) ##1 (run_ok && instr_op == OP_ENTER) |=> !osc_enable)
    else $error("Back-up not entered after arm then enter");
  AST_NOARM : assert property (
    (run_ok && instr_op == OP_OTHER) ##1 (run_ok && instr_op == OP_ENTER) |=> osc_enable)
    else $error("Enter without arm left the run state");
  AST_PINS : assert property (
    !osc_enable |-> cpu_hold && ports_hold && carrier_counter_pin_low)
    else $error("Pin state wrong in back-up");
  AST_VDF : assert property (
    supply_drop_enable == osc_enable && supply_drop_flag == (supply_drop_level && osc_enable))
    else $error("Supply-drop detection active in back-up");
  AST_STAB : assert property (
    $rose(osc_enable) && cpu_hold |-> ##39 cpu_hold ##1 (!cpu_hold && cpu_restart))
    else $error("Oscillator wait before restart has wrong length");
  AST_PHOLD : assert property (
    powerdown_flag |=> powerdown_flag)
    else $error("Power-down flag lost without cold start");
  AST_PSET : assert property (
    $fell(osc_enable) |-> powerdown_flag && backup_init && stack_init_val == SP_BACKUP_VAL)
    else $error("Entry did not set flag and initialise state");
  AST_SKIP : assert property (
    (run_ok && instr_op == OP_SKIP_WARM) |=> skip_next == $past(powerdown_flag))
    else $error("Skip result does not follow power-down flag");
  CVR_ENTRY : cover property ($fell(osc_enable));
  CVR_WAKE : cover property ($rose(osc_enable));
  CVR_SKIP : cover property (skip_next);
endmodule : rbw_ctrl_monitor

bind rbw_ctrl rbw_ctrl_monitor u_mon (.clk(clk), .rst(rst), .instr_valid(instr_valid),
  .instr_op(instr_op), .reset_pin_n(reset_pin_n), .soft_system_reset_cmd(soft_system_reset_cmd),
  .watchdog_reset(watchdog_reset), .power_on_reset(power_on_reset),
  .supply_drop_reset(supply_drop_reset), .supply_drop_level(supply_drop_level),
  .osc_enable(osc_enable), .cpu_hold(cpu_hold), .cpu_restart(cpu_restart),
  .backup_init(backup_init), .stack_init_val(stack_init_val), .ports_hold(ports_hold),
  .carrier_counter_pin_low(carrier_counter_pin_low), .supply_drop_enable(supply_drop_enable),
  .supply_drop_flag(supply_drop_flag), .powerdown_flag(powerdown_flag), .skip_next(skip_next));
`default_nettype wire

// ==== rbw_ctrl_tb.sv ====
// Self-checking bench for the back-up and wakeup controller
`default_nettype none
module rbw_ctrl_tb
  import rbw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] WC [5] = '{4'h0, 4'h1, 4'h3, 4'hc, 4'h4};
  localparam logic [3:0] C0 [5] = '{4'h0, 4'h0, 4'h4, 4'h0, 4'h0};
  localparam logic [3:0] C1 [5] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4};
  localparam logic [1:0] PIN_IDLE [5] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h1};
  localparam logic [1:0] PIN_WAKE [5] = '{2'h3, 2'h2, 2'h3, 2'h1, 2'h3};
  logic       clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, sd_level = 1'b0;
  rbw_op_t    instr_op = OP_NONE;
  logic [3:0] sel = 4'h0, acc = 4'h0, ex [9];
  logic [4:0] cold_v = 5'h0;
  int         n_mismatch = 0, cmp_count = 0;
  logic [3:0] acc_out, p0, p1, pu0, pu1, pu2, ic0, ic1;
  logic [1:0] p2;
  logic       pk, i0, i1, skip_next, osc, hold, restart, binit, phold, cc_low, sd_flag, f0, f1;
  logic       pflag;
  logic [13:0] raddr;
  always #25 clk = ~clk;
  rbw_key_model km (.port0_in(p0), .port1_in(p1), .port2_in(p2), .port_k_in(pk),
    .irq_pin0(i0), .irq_pin1(i1));
  rbw_ctrl uut (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_reg_sel(sel), .acc_in(acc), .acc_out(acc_out), .skip_next(skip_next),
    .reset_pin_n(~cold_v[0]), .soft_system_reset_cmd(cold_v[1]), .watchdog_reset(cold_v[2]),
    .power_on_reset(cold_v[3]), .supply_drop_reset(cold_v[4]), .supply_drop_level(sd_level),
    .port0_in(p0), .port1_in(p1), .port2_in(p2), .port_k_in(pk), .ext_irq_pin_zero(i0),
    .ext_irq_pin_one(i1), .osc_enable(osc), .cpu_hold(hold), .cpu_restart(restart),
    .restart_addr(raddr), .backup_init(binit), .stack_init_val(), .ports_hold(phold),
    .carrier_counter_pin_low(cc_low), .supply_drop_enable(), .supply_drop_flag(sd_flag),
    .ext_irq0_flag_set(f0), .ext_irq1_flag_set(f1), .powerdown_flag(pflag),
    .pullup_port0(pu0), .pullup_port1(pu1), .pullup_port2(pu2), .irq0_pin_control(ic0),
    .irq1_pin_control(ic1));
  function automatic logic [1:0] exp_flags(input int src);
    return {src == 3, src == 2};
  endfunction : exp_flags
  function automatic logic [3:0] key_en(input int b, input int s);
    return (s == (b < 4 ? 0 : b < 8 ? 1 : 2)) ?
      4'h1 << (b < 8 ? b % 4 : b == 10 ? 2 : b - 8) : 4'h0;
  endfunction : key_en
  task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic exec(input rbw_op_t op, input logic [3:0] s, input logic [3:0] a);
    instr_valid = 1'b1;
    instr_op = op;
    sel = s;
    acc = a;
    @(negedge clk);
  endtask : exec
  task automatic idle(input int n);
    instr_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic wr(input int s, input logic [3:0] v);
    exec(OP_WRITE_REG, 4'(s), v);
    if (s < 9) ex[s] = v;
  endtask : wr
  task automatic readall();
    for (int s = 0; s < 10; s++) begin
      exec(OP_READ_REG, 4'(s), 4'h0);
      chk("acc_out", acc_out, s < 9 ? ex[s] : 4'h0);
    end
    idle(1);
    chk("pullup_port0", pu0, ex[4]);
    chk("pullup_port1", pu1, ex[5]);
    chk("pullup_port2", pu2, ex[6]);
    chk("irq0_pin_control", ic0, ex[7]);
    chk("irq1_pin_control", ic1, ex[8]);
  endtask : readall
  task automatic backup(input int src, input int b);
    for (int s = 0; s < 3; s++) wr(s, src == 0 ? key_en(b, s) : 4'h0);
    wr(3, WC[src]);
    wr(7, C0[src]);
    wr(8, C1[src]);
    km.set_pins(PIN_IDLE[src]);
    idle(1);
    exec(OP_OTHER, 4'h0, 4'h0);
    exec(OP_ARM, 4'h0, 4'h0);
    exec(OP_ENTER, 4'h0, 4'h0);
    instr_valid = 1'b0;
    sd_level = 1'b1;
    cold_v[4] = 1'b1;
    chk("osc_enable", osc, 4'h0);
    chk("backup_init", binit, 4'h1);
    chk("carrier_low", cc_low, 4'h1);
    chk("ports_hold", phold, 4'h1);
    chk("powerdown_flag", pflag, 4'h1);
    // A disabled key and a supply-drop reset must both leave back-up alone
    if (src == 0) km.press(b == 10 ? 0 : b + 1);
    @(negedge clk);
    cold_v[4] = 1'b0;
    chk("supply_drop_flag", sd_flag, 4'h0);
    repeat (3) @(negedge clk);
    km.release_all();
    chk("osc_enable", osc, 4'h0);
    @(negedge clk);
    if (src == 0) km.press(b);
    else km.set_pins(PIN_WAKE[src]);
    @(negedge clk);
    chk("osc_enable", osc, 4'h1);
    chk("carrier_low", cc_low, 4'h0);
    chk("ext_flags", {f1, f0}, exp_flags(src));
    repeat (39) @(negedge clk);
    chk("cpu_hold", hold, 4'h1);
    @(negedge clk);
    chk("cpu_restart", restart, 4'h1);
    chk("cpu_hold", hold, 4'h0);
    chk("restart_addr", raddr, RESTART_ADDR);
    km.release_all();
    sd_level = 1'b0;
    exec(OP_SKIP_WARM, 4'h0, 4'h0);
    chk("skip_next", skip_next, 4'h1);
    readall();
  endtask : backup
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    #(50 * 20000);
    n_mismatch++;
    final_report();
  end
  initial begin
    void'($urandom(32'h2a73945d));
    for (int s = 0; s < 9; s++) ex[s] = 4'h0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    readall();
    exec(OP_SKIP_WARM, 4'h0, 4'h0);
    chk("skip_next", skip_next, 4'h0);
    repeat (24) wr($urandom_range(9), 4'($urandom));
    readall();
    sd_level = 1'b1;
    idle(1);
    chk("supply_drop_flag", sd_flag, 4'h1);
    sd_level = 1'b0;
    // Arm is spent by any instruction in between, so enter must stay a no-op
    exec(OP_ARM, 4'h0, 4'h0);
    exec(OP_OTHER, 4'h0, 4'h0);
    exec(OP_ENTER, 4'h0, 4'h0);
    chk("osc_enable", osc, 4'h1);
    chk("backup_init", binit, 4'h0);
    idle(1);
    for (int src = 0; src < 5; src++) backup(src, $urandom_range(10));
    for (int c = 0; c < 5; c++) begin
      backup(0, c);
      cold_v[c] = 1'b1;
      @(negedge clk);
      cold_v[c] = 1'b0;
      chk("powerdown_flag", pflag, 4'h0);
      chk("cpu_restart", restart, 4'h1);
      chk("restart_addr", raddr, RESTART_ADDR);
      for (int s = 0; s < 9; s++) ex[s] = 4'h0;
      idle(2);
      exec(OP_SKIP_WARM, 4'h0, 4'h0);
      chk("skip_next", skip_next, 4'h0);
      readall();
    end
    final_report();
  end
endmodule : rbw_ctrl_tb
`default_nettype wire

// ==== rbw_fall_wake.sv ====
// Per-bit falling-edge and low-level wakeup detector
`default_nettype none
module rbw_fall_wake
  import rbw_pkg::*;
#(
  parameter int unsigned W = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         watch,
  input  wire logic [W-1:0] sample,
  input  wire logic [W-1:0] enable,
  output logic      [W-1:0] fall_hit,
  output logic      [W-1:0] low_hit
);
  logic [W-1:0] prev_q;

  // Previous level tracks continuously so the first back-up cycle sees the
  // level from before entry
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= '1;
    end else begin
      prev_q <= sample;
    end
  end

  assign fall_hit = {W{watch}} & enable & prev_q & ~sample;
  assign low_hit  = {W{watch}} & enable & ~sample;
endmodule : rbw_fall_wake
`default_nettype wire

// ==== rbw_key_model.sv ====
// Key switches and interrupt pins outside the controller
`default_nettype none
module rbw_key_model (
  output logic [3:0] port0_in,
  output logic [3:0] port1_in,
  output logic [1:0] port2_in,
  output logic       port_k_in,
  output logic       irq_pin0,
  output logic       irq_pin1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Open switches sit high on their pull-ups before and between presses
  logic [10:0] keys_q = 11'h7ff;
  logic [1:0]  pins_q = 2'h3;
  assign port0_in  = keys_q[3:0];
  assign port1_in  = keys_q[7:4];
  assign port2_in  = keys_q[9:8];
  assign port_k_in = keys_q[10];
  assign irq_pin0  = pins_q[0];
  assign irq_pin1  = pins_q[1];
  task automatic press(input int b);
    keys_q[b] = 1'b0;
  endtask : press
  task automatic release_all();
    keys_q = 11'h7ff;
  endtask : release_all
  task automatic set_pins(input logic [1:0] v);
    pins_q = v;
  endtask : set_pins
endmodule : rbw_key_model
`default_nettype wire

// ==== rbw_pkg.sv ====
// Shared constants and types for the RAM back-up and wakeup controller
`default_nettype none
package rbw_pkg;
  localparam int unsigned NIB_W         = 4;
  localparam int unsigned NUM_REGS      = 9;
  localparam int unsigned REG_IDX_W     = 4;
  // Register slots reached by the accumulator transfer commands
  localparam logic [3:0]  REG_KEY_WAKE0 = 4'h0;
  localparam logic [3:0]  REG_KEY_WAKE1 = 4'h1;
  localparam logic [3:0]  REG_KEY_WAKEK2 = 4'h2;
  localparam logic [3:0]  REG_WAKE_COND = 4'h3;
  localparam logic [3:0]  REG_PULLUP0   = 4'h4;
  localparam logic [3:0]  REG_PULLUP1   = 4'h5;
  localparam logic [3:0]  REG_PULLUP2   = 4'h6;
  localparam logic [3:0]  REG_IRQ0_CTL  = 4'h7;
  localparam logic [3:0]  REG_IRQ1_CTL  = 4'h8;
  localparam logic [3:0]  REG_RESET_VAL = 4'h0;
  // Wake condition register fields
  localparam int unsigned WC_IRQ0_EN    = 0;
  localparam int unsigned WC_IRQ0_EDGE  = 1;
  localparam int unsigned WC_IRQ1_EN    = 2;
  localparam int unsigned WC_IRQ1_EDGE  = 3;
  // Interrupt pin control: bit giving the valid level (1 = high / rising)
  localparam int unsigned PIN_POL_BIT   = 2;
  // Key wake K2 register fields
  localparam int unsigned K2_P20        = 0;
  localparam int unsigned K2_P21        = 1;
  localparam int unsigned K2_PORTK      = 2;
  localparam int unsigned KEY_BITS      = 11;
  // Program restart point and stack pointer value after back-up
  localparam logic [13:0] RESTART_ADDR  = 14'h0000;
  localparam logic [2:0]  SP_BACKUP_VAL = 3'h7;
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned OSC_STAB_NS   = 2000;
  localparam int unsigned OSC_STAB_CYC  =
    (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STAB_CNT_W    = 12;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ARM,
    OP_ENTER,
    OP_SKIP_WARM,
    OP_WRITE_REG,
    OP_READ_REG,
    OP_OTHER
  } rbw_op_t;

  typedef enum {
    ST_RUN,
    ST_BACKUP,
    ST_STABILISE
  } rbw_state_t;
endpackage : rbw_pkg
`default_nettype wire

// ==== rbw_reg_if.sv ====
// Carrier between the controller and one retained control register
`default_nettype none
interface rbw_reg_if #(parameter int unsigned W = 4);
  logic         wr;
  logic [W-1:0] wdata;
  logic         clr;
  logic [W-1:0] q;
  modport host  (output wr, output wdata, output clr, input q);
  modport store (input wr, input wdata, input clr, output q);
endinterface : rbw_reg_if
`default_nettype wire
